// >>> inc/ebca_pkg.sv
package ebca_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_BUS_CTRL = 8'h00;
	localparam logic [7:0] OFS_OP_MODE  = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;

	// bus control register fields
	localparam int         BCR_WS_LSB   = 0;
	localparam int         BCR_WS_W     = 4;
	localparam int         BCR_HOLD_BIT = 8;

	// operating mode register fields
	localparam int         OMR_ACK_ASYNC_BIT = 0;
	localparam int         OMR_ABE_BIT       = 13;

	// status register fields
	localparam int         STS_OWNER_BIT = 0;
	localparam int         STS_CYC_BIT   = 1;
	localparam int         STS_REQ_BIT   = 2;
	localparam int         STS_ARB_LSB   = 4;

	// values after reset
	localparam logic [3:0] RST_WAIT_STATES = 4'h1;
	localparam logic       RST_HOLD        = 1'b0;
	localparam logic       RST_ACK_ASYNC   = 1'b0;
	localparam logic       RST_ABE         = 1'b0;

	// synchroniser width: ack, grant, busy
	localparam int         SYNC_W = 3;

	typedef enum logic [3:0] {
		ARB_SLAVE = 4'b0001,
		ARB_WAIT  = 4'b0010,
		ARB_OWNER = 4'b0100,
		ARB_REL   = 4'b1000
	} ebca_arb_t;

	typedef enum logic [2:0] {
		CYC_IDLE = 3'b001,
		CYC_WAIT = 3'b010,
		CYC_END  = 3'b100
	} ebca_cyc_t;

endpackage

// >>> core/ebca_sync.sv
`timescale 1ns/10ps
module ebca_sync
	import ebca_pkg::*;
(
	// clock, reset and enable
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	// pins in, synchronised out
	input  wire logic [SYNC_W-1:0] d,
	output logic      [SYNC_W-1:0] q
);

	logic [SYNC_W-1:0] meta_q;

	// two flops per bit, idle level high
	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					meta_q[i] <= 1'b1;
					q[i]      <= 1'b1;
				end else if (ce) begin
					meta_q[i] <= d[i];
					q[i]      <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// >>> core/ebca_top.sv
`timescale 1ns/10ps
module ebca_top
	import ebca_pkg::*;
(
	// clock, reset, enable
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	input  wire logic        CE,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// core side external access port
	input  wire logic        CORE_REQ,
	input  wire logic        CORE_WRITE,
	input  wire logic        STANDBY,
	output logic             CORE_ACK,
	// external bus pins
	output logic             WRITE_STROBE_N_O,
	output logic             WRITE_STROBE_N_OE,
	input  wire logic        TRANSFER_ACK_N,
	output logic             BUS_REQUEST_N,
	input  wire logic        BUS_GRANT_N,
	input  wire logic        BUS_BUSY_N_I,
	output logic             BUS_BUSY_N_O,
	output logic             BUS_BUSY_N_OE
);

	typedef struct packed {
		ebca_arb_t             arb;
		ebca_cyc_t             cyc;
		logic [BCR_WS_W-1:0]   cnt;
		logic                  wr_cyc;
		logic                  br_n;
		logic                  bb_o;
		logic                  bb_oe;
		logic                  wr_n;
		logic                  wr_oe;
		logic                  ack;
		logic [BCR_WS_W-1:0]   ws;
		logic                  hold;
		logic                  ack_async;
		logic                  abe;
		logic                  pready;
		logic                  pslverr;
		logic [31:0]           prdata;
		logic [SYNC_W-1:0]     pin_s3;
	} ebca_state_t;

	ebca_state_t       s_q;
	ebca_state_t       s_d;
	logic [SYNC_W-1:0] pin_s2;
	logic              ack_low;
	logic              grant_low;
	logic              busy_low;
	logic              cyc_done;

	// pin synchronisers: ack, grant, busy
	ebca_sync u_sync (
		.clk  (CLK_SYS),
		.nrst (NRST),
		.ce   (CE),
		.d    ({TRANSFER_ACK_N, BUS_GRANT_N, BUS_BUSY_N_I}),
		.q    (pin_s2)
	);

	// apb access phase decode
	function automatic logic apb_access(input logic sel, input logic en);
		return sel & en;
	endfunction

	// mapped address decode
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == OFS_BUS_CTRL) || (a == OFS_OP_MODE) ||
			(a == OFS_STATUS);
	endfunction

	// pick direct or extra-stage view of each pin
	assign ack_low   = s_q.ack_async ? !s_q.pin_s3[2] : !pin_s2[2];
	assign grant_low = s_q.abe ? !s_q.pin_s3[1] : !pin_s2[1];
	assign busy_low  = s_q.abe ? !s_q.pin_s3[0] : !pin_s2[0];
	assign cyc_done  = (s_q.cyc == CYC_END);

	// next state
	always_comb begin
		s_d        = s_q;
		s_d.pin_s3 = pin_s2;
		s_d.ack    = 1'b0;

		// apb slave: one wait cycle, then ready
		if (apb_access(PSEL, PENABLE) && !s_q.pready) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = !addr_mapped(PADDR);
			s_d.prdata  = 32'h0000_0000;
			case (PADDR)
				OFS_BUS_CTRL: begin
					s_d.prdata[BCR_WS_LSB +: BCR_WS_W] = s_q.ws;
					s_d.prdata[BCR_HOLD_BIT]           = s_q.hold;
				end
				OFS_OP_MODE: begin
					s_d.prdata[OMR_ACK_ASYNC_BIT] = s_q.ack_async;
					s_d.prdata[OMR_ABE_BIT]       = s_q.abe;
				end
				OFS_STATUS: begin
					s_d.prdata[STS_OWNER_BIT] = (s_q.arb == ARB_OWNER);
					s_d.prdata[STS_CYC_BIT]   = (s_q.cyc != CYC_IDLE);
					s_d.prdata[STS_REQ_BIT]   = !s_q.br_n;
					s_d.prdata[STS_ARB_LSB +: 4] = s_q.arb;
				end
				default: s_d.prdata = 32'h0000_0000;
			endcase
		end else if (apb_access(PSEL, PENABLE) && s_q.pready) begin
			s_d.pready  = 1'b0;
			s_d.pslverr = 1'b0;
			if (PWRITE) begin
				case (PADDR)
					OFS_BUS_CTRL: begin
						s_d.ws   = PWDATA[BCR_WS_LSB +: BCR_WS_W];
						s_d.hold = PWDATA[BCR_HOLD_BIT];
					end
					OFS_OP_MODE: begin
						s_d.ack_async = PWDATA[OMR_ACK_ASYNC_BIT];
						s_d.abe       = PWDATA[OMR_ABE_BIT];
					end
					default: s_d.ws = s_q.ws;
				endcase
			end
		end else begin
			s_d.pready  = 1'b0;
			s_d.pslverr = 1'b0;
		end

		// bus request: external need or hold; in standby dropped, or frozen while hold is set
		if (STANDBY) begin
			if (!s_q.hold)
				s_d.br_n = 1'b1;
		end else begin
			s_d.br_n = !((CORE_REQ && !s_q.ack) || s_q.hold);
		end

		// arbitration, independent of the request output
		case (s_q.arb)
			ARB_SLAVE: begin
				if (grant_low)
					s_d.arb = ARB_WAIT;
			end
			ARB_WAIT: begin
				if (!grant_low) begin
					s_d.arb = ARB_SLAVE;
				end else if (!busy_low) begin
					s_d.arb   = ARB_OWNER;
					s_d.bb_o  = 1'b0;
					s_d.bb_oe = 1'b1;
				end
			end
			ARB_OWNER: begin
				// parked while grant stays, released at cycle end
				if (!grant_low && (s_q.cyc == CYC_IDLE || cyc_done)) begin
					s_d.arb  = ARB_REL;
					s_d.bb_o = 1'b1;
				end
			end
			ARB_REL: begin
				s_d.arb   = ARB_SLAVE;
				s_d.bb_oe = 1'b0;
			end
			default: begin
				s_d.arb   = ARB_SLAVE;
				s_d.bb_o  = 1'b1;
				s_d.bb_oe = 1'b0;
			end
		endcase

		// external bus cycle
		case (s_q.cyc)
			CYC_IDLE: begin
				if (s_q.arb == ARB_OWNER && CORE_REQ && !STANDBY &&
					!s_q.ack && grant_low) begin
					s_d.cyc    = CYC_WAIT;
					s_d.cnt    = s_q.ws;
					s_d.wr_cyc = CORE_WRITE;
					s_d.wr_n   = !CORE_WRITE;
				end
			end
			CYC_WAIT: begin
				if (s_q.cnt != '0)
					s_d.cnt = s_q.cnt - 1'b1;
				// programmed count runs out before acknowledge counts
				if (s_q.cnt == '0) begin
					if (s_q.ws == '0 || ack_low)
						s_d.cyc = CYC_END;
				end
				// else acknowledge high keeps stretching
			end
			CYC_END: begin
				s_d.cyc    = CYC_IDLE;
				s_d.ack    = 1'b1;
				s_d.wr_n   = 1'b1;
				s_d.wr_cyc = 1'b0;
			end
			default: begin
				s_d.cyc  = CYC_IDLE;
				s_d.wr_n = 1'b1;
			end
		endcase

		// strobe driven only as owner, else released
		s_d.wr_oe = (s_d.arb == ARB_OWNER);
		if (!s_d.wr_oe)
			s_d.wr_n = 1'b1;
	end

	// state register
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			s_q           <= '0;
			s_q.arb       <= ARB_SLAVE;
			s_q.cyc       <= CYC_IDLE;
			s_q.br_n      <= 1'b1;
			s_q.bb_o      <= 1'b1;
			s_q.wr_n      <= 1'b1;
			s_q.ws        <= RST_WAIT_STATES;
			s_q.hold      <= RST_HOLD;
			s_q.ack_async <= RST_ACK_ASYNC;
			s_q.abe       <= RST_ABE;
			s_q.pin_s3    <= '1;
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign PRDATA            = s_q.prdata;
	assign PREADY            = s_q.pready;
	assign PSLVERR           = s_q.pslverr;
	assign CORE_ACK          = s_q.ack;
	assign WRITE_STROBE_N_O  = s_q.wr_n;
	assign WRITE_STROBE_N_OE = s_q.wr_oe;
	assign BUS_REQUEST_N     = s_q.br_n;
	assign BUS_BUSY_N_O      = s_q.bb_o;
	assign BUS_BUSY_N_OE     = s_q.bb_oe;

	// checks
	chk_strobe_owner: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		s_q.wr_oe |-> s_q.arb == ARB_OWNER)
		else $error("write strobe driven while not owner");

	chk_ack_ignored: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(s_q.cyc == CYC_IDLE) |=> (s_q.cyc != CYC_END))
		else $error("cycle ended without a cycle in progress");

	chk_cycle_stretch: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CE && s_q.cyc == CYC_WAIT && s_q.cnt == '0 && s_q.ws != '0 &&
		!ack_low) |=> s_q.cyc == CYC_WAIT)
		else $error("cycle ended while acknowledge deasserted");

	chk_ack_finish: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CE && s_q.cyc == CYC_WAIT && s_q.cnt == '0 && ack_low) ##1 CE
		|=> (s_q.cyc == CYC_IDLE && s_q.ack))
		else $error("cycle did not finish one clock after acknowledge");

	chk_min_waits: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(s_q.cyc == CYC_END) |-> (s_q.cnt == '0 && $past(s_q.cnt) <= 4'h1))
		else $error("cycle ended before programmed wait states");

	chk_hold_request: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CE && s_q.hold && !STANDBY) |=> !BUS_REQUEST_N)
		else $error("hold bit set but request deasserted");

	chk_standby_req: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CE && STANDBY && !s_q.hold) |=> BUS_REQUEST_N)
		else $error("request asserted in standby without hold");

	chk_own_after_busy: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CE && s_q.arb == ARB_WAIT && grant_low && !busy_low)
		|=> (s_q.arb == ARB_OWNER && BUS_BUSY_N_OE && !BUS_BUSY_N_O))
		else $error("ownership not taken after busy released");

	chk_grant_release: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		(CE && s_q.arb == ARB_OWNER && !grant_low && s_q.cyc == CYC_IDLE)
		|=> (s_q.arb == ARB_REL))
		else $error("ownership kept after grant withdrawn");

endmodule

// >>> sim/ebca_far.sv
`timescale 1ns/10ps
module ebca_far (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// bench controls
	input  wire logic       grant_en,
	input  wire logic [3:0] ack_dly,
	// bus pins
	input  wire logic       bus_request_n,
	input  wire logic       strobe_n,
	input  wire logic       strobe_oe,
	output logic            bus_grant_n,
	output logic            transfer_ack_n
);
	logic [3:0] cnt_q;
	logic [2:0] gap_q;
	logic       strb;

	// arbiter: grant on request, park until withdrawn, space grants
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_grant_n <= 1'b1;
			gap_q       <= 3'h0;
		end else if (!bus_grant_n && !grant_en) begin
			bus_grant_n <= 1'b1;
			gap_q       <= 3'h4;
		end else if (gap_q != 3'h0) begin
			gap_q <= gap_q - 3'h1;
		end else if (grant_en && !bus_request_n) begin
			bus_grant_n <= 1'b0;
		end
	end

	// responder counts strobe cycles before acknowledging
	assign strb = strobe_oe && !strobe_n;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_q <= 4'h0;
		else if (!strb)
			cnt_q <= 4'h0;
		else if (cnt_q != 4'hf)
			cnt_q <= cnt_q + 4'h1;
	end

	// zero delay ties acknowledge low, else high at cycle start
	assign transfer_ack_n = (ack_dly == 4'h0) ? 1'b0 :
		!(strb && cnt_q >= ack_dly);
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb;
	import ebca_pkg::*;
	// bench signals
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        core_req = 1'b0;
	logic        standby = 1'b0;
	logic        grant_en = 1'b1;
	logic        other_busy = 1'b0;
	logic [3:0]  ack_dly = 4'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, core_ack, ws_n, ws_oe, ack_n;
	logic        req_n, gnt_n, bb_o, bb_oe, err;
	logic [3:0]  w, d;
	wire         bus_busy_n = bb_oe ? bb_o : !other_busy;
	integer      seed = 32'h38176f51;
	int          bad_count = 0;
	int          comparisons = 0;
	int          n, k;

	always #20 clk = !clk;

	ebca_top u_dut (.CLK_SYS(clk), .NRST(nrst), .CE(1'b1), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CORE_REQ(core_req), .CORE_WRITE(1'b1),
		.STANDBY(standby), .CORE_ACK(core_ack), .WRITE_STROBE_N_O(ws_n),
		.WRITE_STROBE_N_OE(ws_oe), .TRANSFER_ACK_N(ack_n),
		.BUS_REQUEST_N(req_n), .BUS_GRANT_N(gnt_n),
		.BUS_BUSY_N_I(bus_busy_n), .BUS_BUSY_N_O(bb_o),
		.BUS_BUSY_N_OE(bb_oe));

	ebca_far u_far (.clk(clk), .nrst(nrst), .grant_en(grant_en),
		.ack_dly(ack_dly), .bus_request_n(req_n), .strobe_n(ws_n),
		.strobe_oe(ws_oe), .bus_grant_n(gnt_n), .transfer_ack_n(ack_n));

	// verdict and end of run
	task automatic complete_run;
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a bound ran out
	task automatic hang(input int i, input int lim);
		if (i >= lim) begin
			bad_count++;
			complete_run();
		end
	endtask

	// one apb transfer, waits for pready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] dat);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		hang(i, 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one external write, timed against wait states and ack delay
	task automatic access(input logic [3:0] ws, input logic [3:0] dl);
		int i, lo, hi;
		ack_dly <= dl;
		core_req <= 1'b1;
		for (i = 0; i < 300 && ws_n !== 1'b0; i++) @(posedge clk);
		hang(i, 300);
		chk(32'({ws_oe, bb_oe, bb_o, req_n}), 32'hc);
		for (n = 0; n < 300 && core_ack !== 1'b1; n++) @(posedge clk);
		hang(n, 300);
		// acknowledge blocks a restart on this edge, request drops after
		core_req <= 1'b0;
		lo = (ws > dl) ? ws + 2 : dl + 2;
		hi = (ws + 2 > dl + 6) ? ws + 2 : dl + 6;
		if (dl == 4'h0)
			chk(32'(n), 32'(ws) + 32'h2);
		else
			chk(32'(n >= lo && n <= hi), 32'h1);
		grant_en <= 1'b0;
		for (i = 0; i < 50 && bb_oe !== 1'b0; i++) @(posedge clk);
		hang(i, 50);
		chk(32'({ws_oe, req_n}), 32'h1);
		grant_en <= 1'b1;
		@(posedge clk);
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		chk(32'({ws_oe, bb_oe, req_n}), 32'h1);
		nrst <= 1'b1;
		apb(1'b0, OFS_BUS_CTRL, 32'h0);
		chk(rd, {23'h0, RST_HOLD, 4'h0, RST_WAIT_STATES});
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h10);
		apb(1'b1, 8'h0c, 32'h5);
		chk(32'(err), 32'h1);
		for (k = 0; k < 7; k++) begin
			w = (k == 0) ? 4'h1 : 4'(1 + $unsigned($random(seed)) % 15);
			d = (k < 2) ? 4'h0 : 4'(1 + $unsigned($random(seed)) % 12);
			if (k == 4) begin
				apb(1'b1, OFS_OP_MODE, 32'h2001);
				chk(rd, 32'h0);
				apb(1'b0, OFS_OP_MODE, 32'h0);
				chk(rd, 32'h2001);
			end
			apb(1'b1, OFS_BUS_CTRL, {28'h0, w});
			access(w, d);
		end
		// hold bit and standby
		apb(1'b1, OFS_BUS_CTRL, 32'h101);
		repeat (4) @(posedge clk);
		chk(32'(req_n), 32'h0);
		standby <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(req_n), 32'h0);
		apb(1'b1, OFS_BUS_CTRL, 32'h1);
		core_req <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(req_n), 32'h1);
		core_req <= 1'b0;
		standby <= 1'b0;
		// another master keeps the bus busy while we are granted
		grant_en <= 1'b0;
		other_busy <= 1'b1;
		repeat (12) @(posedge clk);
		grant_en <= 1'b1;
		core_req <= 1'b1;
		repeat (12) @(posedge clk);
		chk(32'({ws_oe, bb_oe, req_n}), 32'h0);
		other_busy <= 1'b0;
		access(4'h1, 4'h0);
		complete_run();
	end
endmodule
